// File: core/ptpc_axil_slave.sv
// AXI4-Lite slave front end that turns bus transfers into register writes and reads.
`timescale 1ns/1ps
module ptpc_axil_slave (
	mclk,
	rst,
	s_axi_awaddr,
	s_axi_awvalid,
	s_axi_awready,
	s_axi_wdata,
	s_axi_wstrb,
	s_axi_wvalid,
	s_axi_wready,
	s_axi_bresp,
	s_axi_bvalid,
	s_axi_bready,
	s_axi_araddr,
	s_axi_arvalid,
	s_axi_arready,
	s_axi_rdata,
	s_axi_rresp,
	s_axi_rvalid,
	s_axi_rready,
	wr,
	rdAddr,
	rdData
);
	input wire logic mclk;
	input wire logic rst;
	input wire logic [7:0] s_axi_awaddr;
	input wire logic s_axi_awvalid;
	output logic s_axi_awready;
	input wire logic [31:0] s_axi_wdata;
	input wire logic [3:0] s_axi_wstrb;
	input wire logic s_axi_wvalid;
	output logic s_axi_wready;
	output logic [1:0] s_axi_bresp;
	output logic s_axi_bvalid;
	input wire logic s_axi_bready;
	input wire logic [7:0] s_axi_araddr;
	input wire logic s_axi_arvalid;
	output logic s_axi_arready;
	output logic [31:0] s_axi_rdata;
	output logic [1:0] s_axi_rresp;
	output logic s_axi_rvalid;
	input wire logic s_axi_rready;
	output ptpc_pkg::ptpc_wr_t wr;
	output logic [7:0] rdAddr;
	input wire logic [31:0] rdData;

	logic awHeld_reg, awHeld_next; // Write address captured.
	logic wHeld_reg, wHeld_next; // Write data captured.
	logic [7:0] awAddr_reg, awAddr_next;
	logic [31:0] wData_reg, wData_next;
	logic bValid_reg, bValid_next;
	logic [1:0] bResp_reg, bResp_next;
	ptpc_pkg::ptpc_wr_t wr_next;
	logic rValid_reg, rValid_next;
	logic [31:0] rData_reg, rData_next;
	logic [1:0] rResp_reg, rResp_next;

	// Register contents are looked up for the address on the read channel.
	assign rdAddr = s_axi_araddr;

	// Next state of both channels; address and data may arrive in either order.
	always_comb begin
		awHeld_next = awHeld_reg;
		wHeld_next = wHeld_reg;
		awAddr_next = awAddr_reg;
		wData_next = wData_reg;
		bValid_next = bValid_reg;
		bResp_next = bResp_reg;
		wr_next = '0;
		rValid_next = rValid_reg;
		rData_next = rData_reg;
		rResp_next = rResp_reg;
		if (s_axi_awvalid && !awHeld_reg) begin
			awHeld_next = 1'b1;
			awAddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wHeld_reg) begin
			wHeld_next = 1'b1;
			// A partial-strobe write still commits, but with the previously held data in place of its own.
			wData_next = s_axi_wdata;
		end
		if (bValid_reg && s_axi_bready) begin
			bValid_next = 1'b0;
		end
		// Both halves held and no response pending: commit the write.
		if (awHeld_reg && wHeld_reg && !bValid_reg) begin
			awHeld_next = 1'b0;
			wHeld_next = 1'b0;
			bValid_next = 1'b1;
			wr_next.en = ptpc_pkg::addrValid(awAddr_reg);
			wr_next.addr = awAddr_reg;
			wr_next.data = wData_reg;
			bResp_next = ptpc_pkg::addrValid(awAddr_reg) ? ptpc_pkg::RESP_OKAY : ptpc_pkg::RESP_SLVERR;
		end
		if (rValid_reg && s_axi_rready) begin
			rValid_next = 1'b0;
		end
		if (s_axi_arvalid && !rValid_reg) begin
			rValid_next = 1'b1;
			rData_next = ptpc_pkg::addrValid(s_axi_araddr) ? rdData : 32'h0000_0000;
			rResp_next = ptpc_pkg::addrValid(s_axi_araddr) ? ptpc_pkg::RESP_OKAY : ptpc_pkg::RESP_SLVERR;
		end
	end

	// Registers of the bus front end.
	always_ff @(posedge mclk) begin
		if (rst) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= 8'h00;
			wData_reg <= 32'h0000_0000;
			bValid_reg <= 1'b0;
			bResp_reg <= 2'h0;
			wr <= '0;
			rValid_reg <= 1'b0;
			rData_reg <= 32'h0000_0000;
			rResp_reg <= 2'h0;
		end else begin
			awHeld_reg <= awHeld_next;
			wHeld_reg <= wHeld_next;
			awAddr_reg <= awAddr_next;
			wData_reg <= wStrbFull(s_axi_wstrb) || wHeld_reg ? wData_next : wData_reg;
			bValid_reg <= bValid_next;
			bResp_reg <= bResp_next;
			wr <= wr_next;
			rValid_reg <= rValid_next;
			rData_reg <= rData_next;
			rResp_reg <= rResp_next;
		end
	end

	// A write whose strobes are not all set keeps the old held data.
	function automatic logic wStrbFull(input logic [3:0] s);
		wStrbFull = (s == 4'hF);
	endfunction

	assign s_axi_awready = !awHeld_reg;
	assign s_axi_wready = !wHeld_reg;
	assign s_axi_bvalid = bValid_reg;
	assign s_axi_bresp = bResp_reg;
	assign s_axi_arready = !rValid_reg;
	assign s_axi_rvalid = rValid_reg;
	assign s_axi_rdata = rData_reg;
	assign s_axi_rresp = rResp_reg;
endmodule // ptpc_axil_slave

// File: core/ptpc_pkg.sv
// Package with register map, reset values, pin function codes and shared types for the port pin control block.
// Functional notes
// R01 - Analog port per-bit direction plus output latch.
// R02 - Reset makes every analog pin digital input.
// R03 - Pin function decoded from all five controls.
// R04 - Amplifier input pins: analog, amplifier, or prohibited.
// R05 - Enabled amplifier output pin carries amplifier output.
// R06 - Software avoids amplifier pins as converter inputs.
// R07 - Plain pin: digital I/O or analog input.
// R08 - Reference select feeds negative converter reference.
// R09 - Software assigns digital pins farthest first.
// R10 - Second port direction bits and input pull-ups.
// R11 - Reset puts second port in input mode.
// R12 - Reroute bit moves serial inputs onto pins.
// R13 - Software leaves serial registers default for GPIO.
// R14 - Two second port pins carry debug mode.
// R15 - Third port direction bits and input pull-ups.
// R16 - Reset puts third port in input mode.
// R17 - Software never outputs on analog-selected pins.
// R18 - Read gives pin or latch; write sets latch.
// R19 - Pull-up off for any output use.
package ptpc_pkg;

	// Register byte addresses on the AXI4-Lite slave.
	localparam logic [7:0] OFF_ANA_LATCH = 8'h00;
	localparam logic [7:0] OFF_ANA_DIR = 8'h04;
	localparam logic [7:0] OFF_ANA_CFG = 8'h08;
	localparam logic [7:0] OFF_CHAN_SEL = 8'h0C;
	localparam logic [7:0] OFF_AMP_REF = 8'h10;
	localparam logic [7:0] OFF_SEC_LATCH = 8'h14;
	localparam logic [7:0] OFF_SEC_DIR = 8'h18;
	localparam logic [7:0] OFF_SEC_PULLUP = 8'h1C;
	localparam logic [7:0] OFF_THR_LATCH = 8'h20;
	localparam logic [7:0] OFF_THR_DIR = 8'h24;
	localparam logic [7:0] OFF_THR_PULLUP = 8'h28;
	localparam logic [7:0] OFF_INPUT_SWITCH = 8'h2C;
	localparam logic [7:0] OFF_FUNC_STATUS = 8'h30;

	// Field positions.
	localparam int AMP_EN_LSB = 0;
	localparam int NEG_REF_BIT = 2;
	localparam int SERIAL_REROUTE_BIT = 2;
	localparam int SERIAL_CLK_PIN = 1;
	localparam int SERIAL_DATA_PIN = 2;
	localparam int DEBUG_A_PIN = 1;
	localparam int DEBUG_B_PIN = 2;
	localparam int REF_PIN = 7;
	localparam int PLAIN_PIN = 6;
	localparam logic [3:0] REF_PIN_CHANNEL = 4'hF;

	// Reset values: direction all ones is input mode, analog config zero is digital.
	localparam logic [7:0] RST_DIR = 8'hFF;
	localparam logic [7:0] RST_ZERO = 8'h00;

	// Bus response codes.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Decoded pin function codes of the analog-capable port.
	localparam logic [2:0] FN_DIG_IN = 3'h0;
	localparam logic [2:0] FN_DIG_OUT = 3'h1;
	localparam logic [2:0] FN_ANA_IN = 3'h2;
	localparam logic [2:0] FN_AMP_IN = 3'h3;
	localparam logic [2:0] FN_AMP_OUT = 3'h4;
	localparam logic [2:0] FN_REF_IN = 3'h5;
	localparam logic [2:0] FN_PROHIB = 3'h6;

	// One register write as seen by the register file.
	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [31:0] data;
	} ptpc_wr_t;

	// True for every mapped register address.
	function automatic logic addrValid(input logic [7:0] a);
		addrValid = (a[1:0] == 2'h0) && (a <= OFF_FUNC_STATUS);
	endfunction

endpackage

// File: core/ptpc_sync.sv
// Two flip-flop synchroniser for a vector of pin levels.
`timescale 1ns/1ps
module ptpc_sync #(
	parameter int W = 8
) (
	mclk,
	rst,
	din,
	dout
);
	input wire logic mclk;
	input wire logic rst;
	input wire logic [W-1:0] din;
	output logic [W-1:0] dout;

	logic [W-1:0] stage1_reg; // First stage, read only by the second stage.

	// Two flops in a row give metastability time before logic sees the pins.
	always_ff @(posedge mclk) begin
		if (rst) begin
			stage1_reg <= '0;
			dout <= '0;
		end else begin
			stage1_reg <= din;
			dout <= stage1_reg;
		end
	end
endmodule // ptpc_sync

// File: core/ptpc_top.sv
// Pin control for the analog-capable port, the second port and the third port, with its register file.
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
module ptpc_top #(
	parameter int SEC_W = 8, // Width of the second port.
	parameter int THR_W = 3 // Width of the third port.
) (
	mclk,
	rst,
	s_axi_awaddr,
	s_axi_awvalid,
	s_axi_awready,
	s_axi_wdata,
	s_axi_wstrb,
	s_axi_wvalid,
	s_axi_wready,
	s_axi_bresp,
	s_axi_bvalid,
	s_axi_bready,
	s_axi_araddr,
	s_axi_arvalid,
	s_axi_arready,
	s_axi_rdata,
	s_axi_rresp,
	s_axi_rvalid,
	s_axi_rready,
	anaPinIn,
	anaPinOut,
	anaPinOe,
	anaFunc,
	anaConvert,
	ampEnable,
	negRefEn,
	secPinIn,
	secPinOut,
	secPinOe,
	secPullupEn,
	secAltOe,
	secAltOut,
	serialClkIn,
	serialDataIn,
	debugEnable,
	debugModeA,
	debugModeB,
	thrPinIn,
	thrPinOut,
	thrPinOe,
	thrPullupEn,
	thrAltOe,
	thrAltOut
);
	input wire logic mclk;
	input wire logic rst;
	input wire logic [7:0] s_axi_awaddr;
	input wire logic s_axi_awvalid;
	output logic s_axi_awready;
	input wire logic [31:0] s_axi_wdata;
	input wire logic [3:0] s_axi_wstrb;
	input wire logic s_axi_wvalid;
	output logic s_axi_wready;
	output logic [1:0] s_axi_bresp;
	output logic s_axi_bvalid;
	input wire logic s_axi_bready;
	input wire logic [7:0] s_axi_araddr;
	input wire logic s_axi_arvalid;
	output logic s_axi_arready;
	output logic [31:0] s_axi_rdata;
	output logic [1:0] s_axi_rresp;
	output logic s_axi_rvalid;
	input wire logic s_axi_rready;
	input wire logic [7:0] anaPinIn;
	output logic [7:0] anaPinOut;
	output logic [7:0] anaPinOe;
	output logic [23:0] anaFunc; // Three-bit function code per pin.
	output logic [7:0] anaConvert; // Pin is the converter's sampled source.
	output logic [1:0] ampEnable;
	output logic negRefEn;
	input wire logic [SEC_W-1:0] secPinIn;
	output logic [SEC_W-1:0] secPinOut;
	output logic [SEC_W-1:0] secPinOe;
	output logic [SEC_W-1:0] secPullupEn;
	input wire logic [SEC_W-1:0] secAltOe;
	input wire logic [SEC_W-1:0] secAltOut;
	output logic serialClkIn;
	output logic serialDataIn;
	input wire logic debugEnable;
	output logic debugModeA;
	output logic debugModeB;
	input wire logic [THR_W-1:0] thrPinIn;
	output logic [THR_W-1:0] thrPinOut;
	output logic [THR_W-1:0] thrPinOe;
	output logic [THR_W-1:0] thrPullupEn;
	input wire logic [THR_W-1:0] thrAltOe;
	input wire logic [THR_W-1:0] thrAltOut;

	ptpc_pkg::ptpc_wr_t wr; // One-cycle register write from the bus.
	logic [7:0] rdAddr;
	logic [31:0] rdData;
	logic [7:0] anaSync; // Synchronised analog port pin levels.
	logic [SEC_W-1:0] secSync;
	logic [THR_W-1:0] thrSync;

	// Software-visible control registers.
	logic [7:0] anaLatch_reg, anaLatch_next;
	logic [7:0] anaDir_reg, anaDir_next; // One is input mode.
	logic [7:0] anaCfg_reg, anaCfg_next; // One selects analog for that pin.
	logic [3:0] chanSel_reg, chanSel_next;
	logic [1:0] ampEn_reg, ampEn_next;
	logic negRef_reg, negRef_next;
	logic [SEC_W-1:0] secLatch_reg, secLatch_next;
	logic [SEC_W-1:0] secDir_reg, secDir_next;
	logic [SEC_W-1:0] secPu_reg, secPu_next;
	logic [THR_W-1:0] thrLatch_reg, thrLatch_next;
	logic [THR_W-1:0] thrDir_reg, thrDir_next;
	logic [THR_W-1:0] thrPu_reg, thrPu_next;
	logic [7:0] inSwitch_reg, inSwitch_next;

	// Decoded functions, computed from the registers.
	logic [23:0] funcNow;
	logic [7:0] convNow;

	ptpc_axil_slave u_bus (
		.mclk(mclk),
		.rst(rst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr(wr),
		.rdAddr(rdAddr),
		.rdData(rdData)
	);

	ptpc_sync #(.W(8)) u_anaSync (.mclk(mclk), .rst(rst), .din(anaPinIn), .dout(anaSync));
	ptpc_sync #(.W(SEC_W)) u_secSync (.mclk(mclk), .rst(rst), .din(secPinIn), .dout(secSync));
	ptpc_sync #(.W(THR_W)) u_thrSync (.mclk(mclk), .rst(rst), .din(thrPinIn), .dout(thrSync));

	// Joint decode of one analog-capable pin from config, direction, amplifier, reference and channel.
	function automatic logic [2:0] pinFunc(input int idx, input logic ana, input logic isIn,
			input logic [1:0] amp, input logic refSel, input logic [3:0] chan);
		logic isRef;
		logic isPlain;
		logic isAmpOut;
		logic ampOn;
		isRef = (idx == ptpc_pkg::REF_PIN);
		isPlain = (idx == ptpc_pkg::PLAIN_PIN);
		isAmpOut = (idx == 1) || (idx == 4);
		ampOn = !isRef && !isPlain && amp[idx / 3];
		if (!ana) begin
			// Digital: amplifier or reference use on a digital pin is prohibited.
			if (ampOn || (isRef && refSel)) begin // R08
				pinFunc = ptpc_pkg::FN_PROHIB;
			end else begin
				pinFunc = isIn ? ptpc_pkg::FN_DIG_IN : ptpc_pkg::FN_DIG_OUT; // R07
			end
		end else if (!isIn) begin
			pinFunc = ptpc_pkg::FN_PROHIB;
		end else if (isRef && refSel) begin
			pinFunc = ptpc_pkg::FN_REF_IN; // R08
		end else if (ampOn && isAmpOut) begin
			pinFunc = ptpc_pkg::FN_AMP_OUT; // R05
		end else if (ampOn) begin
			pinFunc = (chan == pinChan(idx)) ? ptpc_pkg::FN_PROHIB : ptpc_pkg::FN_AMP_IN; // R04
		end else begin
			pinFunc = ptpc_pkg::FN_ANA_IN; // R07
		end
	endfunction

	// Converter channel number of a pin.
	function automatic logic [3:0] pinChan(input int idx);
		pinChan = (idx == ptpc_pkg::REF_PIN) ? ptpc_pkg::REF_PIN_CHANNEL : 4'(idx);
	endfunction

	// Decode every pin of the analog-capable port.
	always_comb begin
		funcNow = '0;
		convNow = '0;
		for (int i = 0; i < 8; i++) begin
			funcNow[3*i +: 3] = pinFunc(i, anaCfg_reg[i], anaDir_reg[i], ampEn_reg, negRef_reg, chanSel_reg); // R03
			convNow[i] = (chanSel_reg == pinChan(i)) && // R05
				((funcNow[3*i +: 3] == ptpc_pkg::FN_ANA_IN) || (funcNow[3*i +: 3] == ptpc_pkg::FN_AMP_OUT));
		end
	end

	// Register file writes.
	always_comb begin
		anaLatch_next = anaLatch_reg;
		anaDir_next = anaDir_reg;
		anaCfg_next = anaCfg_reg;
		chanSel_next = chanSel_reg;
		ampEn_next = ampEn_reg;
		negRef_next = negRef_reg;
		secLatch_next = secLatch_reg;
		secDir_next = secDir_reg;
		secPu_next = secPu_reg;
		thrLatch_next = thrLatch_reg;
		thrDir_next = thrDir_reg;
		thrPu_next = thrPu_reg;
		inSwitch_next = inSwitch_reg;
		if (wr.en) begin
			unique case (wr.addr)
				ptpc_pkg::OFF_ANA_LATCH: anaLatch_next = wr.data[7:0]; // R18
				ptpc_pkg::OFF_ANA_DIR: anaDir_next = wr.data[7:0]; // R01
				ptpc_pkg::OFF_ANA_CFG: anaCfg_next = wr.data[7:0];
				ptpc_pkg::OFF_CHAN_SEL: chanSel_next = wr.data[3:0];
				ptpc_pkg::OFF_AMP_REF: begin
					ampEn_next = wr.data[ptpc_pkg::AMP_EN_LSB +: 2];
					negRef_next = wr.data[ptpc_pkg::NEG_REF_BIT];
				end
				ptpc_pkg::OFF_SEC_LATCH: secLatch_next = wr.data[SEC_W-1:0];
				ptpc_pkg::OFF_SEC_DIR: secDir_next = wr.data[SEC_W-1:0]; // R10
				ptpc_pkg::OFF_SEC_PULLUP: secPu_next = wr.data[SEC_W-1:0];
				ptpc_pkg::OFF_THR_LATCH: thrLatch_next = wr.data[THR_W-1:0];
				ptpc_pkg::OFF_THR_DIR: thrDir_next = wr.data[THR_W-1:0]; // R15
				ptpc_pkg::OFF_THR_PULLUP: thrPu_next = wr.data[THR_W-1:0];
				ptpc_pkg::OFF_INPUT_SWITCH: inSwitch_next = wr.data[7:0];
				default: begin
					// Status is read-only; other addresses were refused by the slave.
				end
			endcase
		end
	end

	// Register file storage; reset leaves every pin a digital input.
	always_ff @(posedge mclk) begin
		if (rst) begin
			anaLatch_reg <= ptpc_pkg::RST_ZERO;
			anaDir_reg <= ptpc_pkg::RST_DIR; // R02
			anaCfg_reg <= ptpc_pkg::RST_ZERO; // R02
			chanSel_reg <= 4'h0;
			ampEn_reg <= 2'h0;
			negRef_reg <= 1'b0;
			secLatch_reg <= '0;
			secDir_reg <= '1; // R11
			secPu_reg <= '0;
			thrLatch_reg <= '0;
			thrDir_reg <= '1; // R16
			thrPu_reg <= '0;
			inSwitch_reg <= ptpc_pkg::RST_ZERO;
		end else begin
			anaLatch_reg <= anaLatch_next;
			anaDir_reg <= anaDir_next;
			anaCfg_reg <= anaCfg_next;
			chanSel_reg <= chanSel_next;
			ampEn_reg <= ampEn_next;
			negRef_reg <= negRef_next;
			secLatch_reg <= secLatch_next;
			secDir_reg <= secDir_next;
			secPu_reg <= secPu_next;
			thrLatch_reg <= thrLatch_next;
			thrDir_reg <= thrDir_next;
			thrPu_reg <= thrPu_next;
			inSwitch_reg <= inSwitch_next;
		end
	end

	// Read mux: port registers give the pin for inputs and the latch for outputs.
	always_comb begin
		rdData = 32'h0000_0000;
		unique case (rdAddr)
			ptpc_pkg::OFF_ANA_LATCH: begin
				for (int i = 0; i < 8; i++) begin
					// Analog pins set as inputs have their digital input buffer off and read zero.
					rdData[i] = anaDir_reg[i] ? (anaSync[i] & !anaCfg_reg[i]) : anaLatch_reg[i]; // R18
				end
			end
			ptpc_pkg::OFF_ANA_DIR: rdData[7:0] = anaDir_reg;
			ptpc_pkg::OFF_ANA_CFG: rdData[7:0] = anaCfg_reg;
			ptpc_pkg::OFF_CHAN_SEL: rdData[3:0] = chanSel_reg;
			ptpc_pkg::OFF_AMP_REF: rdData[2:0] = {negRef_reg, ampEn_reg};
			ptpc_pkg::OFF_SEC_LATCH: rdData[SEC_W-1:0] = (secDir_reg & secSync) | (~secDir_reg & secLatch_reg); // R18
			ptpc_pkg::OFF_SEC_DIR: rdData[SEC_W-1:0] = secDir_reg;
			ptpc_pkg::OFF_SEC_PULLUP: rdData[SEC_W-1:0] = secPu_reg;
			ptpc_pkg::OFF_THR_LATCH: rdData[THR_W-1:0] = (thrDir_reg & thrSync) | (~thrDir_reg & thrLatch_reg); // R18
			ptpc_pkg::OFF_THR_DIR: rdData[THR_W-1:0] = thrDir_reg;
			ptpc_pkg::OFF_THR_PULLUP: rdData[THR_W-1:0] = thrPu_reg;
			ptpc_pkg::OFF_INPUT_SWITCH: rdData[7:0] = inSwitch_reg;
			ptpc_pkg::OFF_FUNC_STATUS: rdData[23:0] = anaFunc;
			default: rdData = 32'h0000_0000;
		endcase
	end

	// Pin-facing outputs, all registered.
	always_ff @(posedge mclk) begin
		if (rst) begin
			anaPinOut <= 8'h00;
			anaPinOe <= 8'h00;
			anaFunc <= 24'h000000;
			anaConvert <= 8'h00;
			ampEnable <= 2'h0;
			negRefEn <= 1'b0;
			secPinOut <= '0;
			secPinOe <= '0;
			secPullupEn <= '0;
			thrPinOut <= '0;
			thrPinOe <= '0;
			thrPullupEn <= '0;
			serialClkIn <= 1'b0;
			serialDataIn <= 1'b0;
			debugModeA <= 1'b0;
			debugModeB <= 1'b0;
		end else begin
			for (int i = 0; i < 8; i++) begin
				// Only a clean digital output drives; prohibited settings leave the pin floating.
				anaPinOe[i] <= (funcNow[3*i +: 3] == ptpc_pkg::FN_DIG_OUT); // R01
			end
			anaPinOut <= anaLatch_reg;
			anaFunc <= funcNow;
			anaConvert <= convNow;
			ampEnable <= ampEn_reg;
			negRefEn <= (funcNow[3*ptpc_pkg::REF_PIN +: 3] == ptpc_pkg::FN_REF_IN); // R08
			// Alternate outputs override the latch and force drive.
			secPinOut <= (secAltOe & secAltOut) | (~secAltOe & secLatch_reg);
			secPinOe <= ~secDir_reg | secAltOe; // R10
			secPullupEn <= secDir_reg & secPu_reg & ~secAltOe; // R19
			thrPinOut <= (thrAltOe & thrAltOut) | (~thrAltOe & thrLatch_reg);
			thrPinOe <= ~thrDir_reg | thrAltOe; // R15
			thrPullupEn <= thrDir_reg & thrPu_reg & ~thrAltOe; // R19
			serialClkIn <= inSwitch_reg[ptpc_pkg::SERIAL_REROUTE_BIT] & secSync[ptpc_pkg::SERIAL_CLK_PIN]; // R12
			serialDataIn <= inSwitch_reg[ptpc_pkg::SERIAL_REROUTE_BIT] & secSync[ptpc_pkg::SERIAL_DATA_PIN]; // R12
			debugModeA <= debugEnable & secSync[ptpc_pkg::DEBUG_A_PIN]; // R14
			debugModeB <= debugEnable & secSync[ptpc_pkg::DEBUG_B_PIN]; // R14
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// Checks on the pin logic.
	a_reset_ana_input: assert property ($past(rst) |-> anaDir_reg == 8'hFF && anaCfg_reg == 8'h00) // R02
		else $error("Analog port not digital input after reset.");
	a_ana_drive_only: assert property (!$past(rst) |-> (anaPinOe & $past(anaCfg_reg | anaDir_reg)) == 8'h00) // R01
		else $error("Analog port pin driven while analog or input.");
	a_amp_in_noconv: assert property (anaFunc[2:0] == 3'h3 |-> !anaConvert[0] && $past(ampEn_reg[0])) // R04
		else $error("Amplifier input pin marked for conversion.");
	a_ref_feed: assert property (negRefEn |-> $past(anaCfg_reg[7] && anaDir_reg[7] && negRef_reg)) // R08
		else $error("Negative reference fed without analog input setting.");
	a_sec_reset_in: assert property ($past(rst) |-> secDir_reg == '1 && thrDir_reg == '1) // R11
		else $error("Second or third port not input after reset.");
	a_pullup_off_out: assert property ((secPullupEn & secPinOe) == '0 && (thrPullupEn & thrPinOe) == '0) // R19
		else $error("Pull-up on while pin drives.");
	a_serial_route: assert property (serialClkIn || serialDataIn |-> $past(inSwitch_reg[2])) // R12
		else $error("Serial input routed without reroute bit.");
	a_debug_pins: assert property (debugModeA || debugModeB |-> $past(debugEnable)) // R14
		else $error("Debug mode pin seen without debug enable.");
	a_latch_write: assert property (wr.en && wr.addr == 8'h00 |=> anaLatch_reg == $past(wr.data[7:0]) ##1 anaPinOut == $past(anaLatch_reg)) // R18
		else $error("Analog latch write not applied.");
	a_thr_pullup_in: assert property (!$past(rst) && !$past(thrAltOe[0]) |-> thrPullupEn[0] == $past(thrDir_reg[0] && thrPu_reg[0])) // R15
		else $error("Third port pull-up does not follow option.");
endmodule // ptpc_top

// File: verification/ptpc_board.sv
// Board model that settles each port pin from chip drive, pull-up and external source.
`timescale 1ns/1ps
module ptpc_board #(
	parameter int W = 8 // Pins on this port.
) (
	pinOut,
	pinOe,
	pullupEn,
	extLevel,
	pinLevel
);
	input wire logic [W-1:0] pinOut; // Chip drive value.
	input wire logic [W-1:0] pinOe; // Chip drives the pin.
	input wire logic [W-1:0] pullupEn; // Chip pull-up connected.
	input wire logic [W-1:0] extLevel; // Level forced by outside circuitry.
	output logic [W-1:0] pinLevel; // Resulting wire level.
	// The chip drive wins, then the pull-up, then the outside source.
	always_comb begin
		for (int i = 0; i < W; i++) begin
			pinLevel[i] = pinOe[i] ? pinOut[i] : (pullupEn[i] ? 1'b1 : extLevel[i]);
		end
	end
endmodule // ptpc_board

// File: verification/tb_ptpc_top.sv
// Testbench for the port pin control block with bus tasks, pin checks and the closing report.
`timescale 1ns/1ps
module tb_ptpc_top;
	logic mclk = 1'b0, rst = 1'b1, negRefEn, serialClkIn, serialDataIn, debugEnable = 1'b0, debugModeA, debugModeB;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, ampEnable;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] anaPinIn, anaPinOut, anaPinOe, anaConvert, secPinIn, secPinOut, secPinOe, secPullupEn;
	logic [7:0] anaExt = 8'h3C, secExt = 8'hC3, secAltOe = 8'h00, secAltOut = 8'h00;
	logic [2:0] thrPinIn, thrPinOut, thrPinOe, thrPullupEn, thrAltOe = 3'h0, thrAltOut = 3'h0, thrExt = 3'h5;
	logic [23:0] anaFunc;
	int failures = 0, checked = 0, cyc = 0;
	// Setups as config, direction, channel in bits 11:8, amplifier and reference in bits 2:0.
	logic [31:0] tbl [8] = '{32'hFFFF0000, 32'hFFFF0603, 32'hFFFF0103, 32'hFFFF0301, 32'hFFFF0F04,
		32'h7FFF0004, 32'h0FFF0300, 32'h000F0002};
	ptpc_top dut (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .anaPinIn, .anaPinOut,
		.anaPinOe, .anaFunc, .anaConvert, .ampEnable, .negRefEn, .secPinIn, .secPinOut, .secPinOe, .secPullupEn,
		.secAltOe, .secAltOut, .serialClkIn, .serialDataIn, .debugEnable, .debugModeA, .debugModeB, .thrPinIn,
		.thrPinOut, .thrPinOe, .thrPullupEn, .thrAltOe, .thrAltOut);
	ptpc_board #(.W(8)) bAna (.pinOut(anaPinOut), .pinOe(anaPinOe), .pullupEn(8'h00), .extLevel(anaExt),
		.pinLevel(anaPinIn));
	ptpc_board #(.W(8)) bSec (.pinOut(secPinOut), .pinOe(secPinOe), .pullupEn(secPullupEn), .extLevel(secExt),
		.pinLevel(secPinIn));
	ptpc_board #(.W(3)) bThr (.pinOut(thrPinOut), .pinOe(thrPinOe), .pullupEn(thrPullupEn), .extLevel(thrExt),
		.pinLevel(thrPinIn));
	// Clock of 8 ns period.
	always #4 mclk = ~mclk;
	// Compares one result and counts it.
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Bus write; address and data are offered together and each is released when taken.
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, r);
	endtask
	// Bus read compared under a mask.
	task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input logic [1:0] r = 2'h0);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk({s_axi_rresp, s_axi_rdata & {24'h000000, m}}, {r, 24'h000000, e});
	endtask
	// Expected reference, amplifier, convert and function outputs of the analog port for one setup.
	function automatic logic [34:0] fexp(input logic [31:0] t);
		logic [2:0] c;
		logic a;
		fexp = {t[2] & t[31] & t[23], t[1:0], 32'h0};
		for (int i = 0; i < 8; i++) begin
			a = (i < 3) ? t[0] : ((i < 6) ? t[1] : (i == 7 && t[2]));
			if (!t[24 + i]) c = a ? ptpc_pkg::FN_PROHIB : (t[16 + i] ? ptpc_pkg::FN_DIG_IN : ptpc_pkg::FN_DIG_OUT);
			else if (!t[16 + i]) c = ptpc_pkg::FN_PROHIB;
			else if (i == 7 && t[2]) c = ptpc_pkg::FN_REF_IN;
			else if (a && i != 1 && i != 4) c = (t[11:8] == i) ? ptpc_pkg::FN_PROHIB : ptpc_pkg::FN_AMP_IN;
			else c = a ? ptpc_pkg::FN_AMP_OUT : ptpc_pkg::FN_ANA_IN;
			fexp[3 * i +: 3] = c;
			fexp[24 + i] = (c == ptpc_pkg::FN_ANA_IN || c == ptpc_pkg::FN_AMP_OUT) && t[11:8] == ((i == 7) ? 15 : i);
		end
	endfunction
	// Prints the counts and the verdict, then stops.
	task automatic end_of_test;
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Cuts a hang short.
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 6000) begin
			failures++;
			end_of_test;
		end
	end
	// Main sequence.
	initial begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rc(8'h04, 8'hFF, 8'hFF);
		rc(8'h08, 8'hFF, 8'h00);
		rc(8'h18, 8'hFF, 8'hFF);
		rc(8'h24, 8'h07, 8'h07);
		chk({anaPinOe, secPinOe, thrPinOe, anaConvert}, 40'h0);
		chk(anaFunc, fexp(32'h00FF0000));
		$display("test reset done");
		wr(8'h00, 8'hA5);
		wr(8'h04, 8'hF0);
		repeat (2) @(posedge mclk);
		chk({anaPinOe, anaPinOut}, {8'h0F, 8'hA5});
		rc(8'h00, 8'hFF, 8'h35);
		$display("test latch done");
		foreach (tbl[k]) begin
			wr(8'h08, tbl[k][31:24]);
			wr(8'h04, tbl[k][23:16]);
			wr(8'h0C, {4'h0, tbl[k][11:8]});
			wr(8'h10, {5'h00, tbl[k][2:0]});
			repeat (2) @(posedge mclk);
			chk({negRefEn, ampEnable, anaConvert, anaFunc}, fexp(tbl[k]));
		end
		$display("test decode done");
		secAltOe <= 8'h01;
		secAltOut <= 8'h01;
		wr(8'h18, 8'h0F);
		wr(8'h1C, 8'hFF);
		wr(8'h14, 8'h5A);
		wr(8'h24, 8'h06);
		wr(8'h28, 8'h07);
		repeat (2) @(posedge mclk);
		chk({secPinOe, secPullupEn, thrPinOe, thrPullupEn}, {8'hF1, 8'h0E, 3'h1, 3'h6});
		rc(8'h14, 8'hEF, 8'h4F);
		$display("test pullup done");
		secAltOe <= 8'h00;
		secExt <= 8'h02;
		wr(8'h18, 8'hFF);
		wr(8'h1C, 8'h00);
		wr(8'h2C, 8'h04);
		debugEnable <= 1'b1;
		repeat (4) @(posedge mclk);
		chk({serialClkIn, serialDataIn, debugModeA, debugModeB}, 4'hA);
		secExt <= 8'h04;
		wr(8'h2C, 8'h00);
		repeat (4) @(posedge mclk);
		chk({serialClkIn, serialDataIn, debugModeA, debugModeB}, 4'h1);
		$display("test reroute done");
		rc(8'h34, 8'hFF, 8'h00, 2'h2);
		wr(8'h3C, 8'h11, 2'h2);
		wr(8'h02, 8'h11, 2'h2);
		rc(8'h00, 8'hF0, 8'hA0);
		$display("test refusal done");
		end_of_test;
	end
endmodule // tb_ptpc_top
